// file: src/csi_core.sv
// cpu stack pointer, status flags and vectored interrupt control
//
// Overview of operation
// - status bit 2 follows negative result
// - status bit 1 set on zero result
// - status bit 0 follows carry
// - register file supports four operand schemes
// - registers mapped to lowest 32 data addresses
// - top six registers form three pointers
// - push decrements, pop increments stack by one
// - calls and interrupt entry decrement by two
// - returns increment stack pointer by two
// - stack pointer resets to last sram address
// - core runs on undivided clock, pipelined
// - register alu operation completes in one cycle
// - take source only with both enables set
// - lower vector address means higher priority
// - relocate bit moves table to boot
// - entry clears global enable, return sets it
// - hardware or write-one clears source flag
// - masked flags stay pending, served by priority
// - level sources request only while present
// - one main instruction after return first
// - status register not saved on entry
// - global mask op blocks interrupts immediately
// - instruction after unmask runs before interrupts
// - response takes five cycles, pushes return
`timescale 1ns/100ps
`default_nettype none
module csi_core
  import csi_pkg::*;
#(
  parameter int NIRQ = 8,
  parameter logic [NIRQ-1:0] LEVEL_MASK = '0,
  parameter logic [7:0] SP_LO_RST = CSI_SP_LO_RST,
  parameter logic [7:0] SP_HI_RST = CSI_SP_HI_RST,
  parameter logic [15:0] BOOT_BASE = CSI_BOOT_BASE
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // instruction boundary and stack commands from decode
  input wire logic instr_done,
  input wire csi_spop_e sp_op,
  input wire logic global_mask_op,
  input wire logic global_unmask_op,
  input wire csi_alu_s alu,
  // io space access
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // register file
  input wire logic [4:0] rd_a,
  input wire logic [4:0] rd_b,
  output logic [7:0] op_a,
  output logic [7:0] op_b,
  output logic [15:0] op_w,
  input wire logic wr_en,
  input wire csi_scheme_e wr_scheme,
  input wire logic [4:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic ds_we,
  input wire logic [4:0] ds_idx,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  input wire csi_ptr_s ptr,
  output logic [15:0] ptr_val,
  // interrupt sources
  input wire logic [NIRQ-1:0] irq_event,
  input wire logic [NIRQ-1:0] irq_enable,
  input wire logic [NIRQ-1:0] flag_clr_wr,
  // interrupt response to the fetch unit
  output logic [NIRQ-1:0] irq_flags,
  output logic irq_busy,
  output logic irq_vector_valid,
  output logic [15:0] irq_vector,
  output logic [15:0] stack_ptr,
  output logic push_ret
);
  //////////////////////////////////////////////////////////////////////////////
  // state machine of the interrupt response, gray from run through entry to vector
  typedef enum logic [1:0] {
    CSI_RUN = 2'b00,
    CSI_ENTRY = 2'b01,
    CSI_VEC = 2'b11
  } csi_state_e;

  csi_state_e state_r, state_nxt;
  logic [15:0] sp_r, sp_nxt;  // stack pointer
  logic [7:0] sr_r, sr_nxt;  // status_flags_reg
  logic [7:0] ccr_r;  // core_control_reg
  logic [NIRQ-1:0] flag_r, flag_nxt;  // flag-type pending bits
  logic [2:0] cnt_r;  // response cycle counter
  logic hold_r;  // one main instruction must run first
  logic [$clog2(NIRQ)-1:0] sel_r;  // granted source
  logic vec_valid_r;
  logic [15:0] vec_r;
  logic push_r;

  logic [NIRQ-1:0] pend;  // pending requests per source
  logic [NIRQ-1:0] cand;  // enabled requests
  logic [NIRQ-1:0] grant_oh;  // one-hot grant
  logic any_req;
  logic [$clog2(NIRQ)-1:0] grant_idx;
  logic take;  // start an interrupt response this cycle
  logic [15:0] vec_base;
  logic wr_sp_lo, wr_sp_hi, wr_sr, wr_ccr;

  //////////////////////////////////////////////////////////////////////////////
  // decode and request qualification
  assign wr_sp_lo = io_we && (io_addr == CSI_SP_LO_OFS);
  assign wr_sp_hi = io_we && (io_addr == CSI_SP_HI_OFS);
  assign wr_sr = io_we && (io_addr == CSI_SR_OFS);
  assign wr_ccr = io_we && (io_addr == CSI_CCR_OFS);
  // flag sources latch, level sources only follow the live condition
  assign pend = (flag_r & ~LEVEL_MASK) | (irq_event & LEVEL_MASK);
  assign cand = pend & irq_enable & {NIRQ{sr_r[CSI_BIT_I]}};
  // mask op gates in the same cycle; hold covers unmask and return
  assign take = (state_r == CSI_RUN) && instr_done && any_req && !hold_r
    && !global_mask_op;
  assign vec_base = ccr_r[CSI_BIT_RELOC] ? BOOT_BASE : 16'h0000;

  csi_irq_arb #(.N(NIRQ)) u_arb (
    .req(cand),
    .any(any_req),
    .idx(grant_idx),
    .onehot(grant_oh)
  );

  csi_regfile #(.NREG(CSI_NREG)) u_rf (
    .clock(clock),
    .rst_n(rst_n),
    .rd_a(rd_a),
    .rd_b(rd_b),
    .op_a(op_a),
    .op_b(op_b),
    .op_w(op_w),
    .wr_en(wr_en),
    .wr_scheme(wr_scheme),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .ds_we(ds_we),
    .ds_idx(ds_idx),
    .ds_wdata(ds_wdata),
    .ds_rdata(ds_rdata),
    .ptr(ptr),
    .ptr_val(ptr_val)
  );

  //////////////////////////////////////////////////////////////////////////////
  // flag next value: set wins over any clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (state_r == CSI_ENTRY && cnt_r == 3'h1) flag_nxt[sel_r] = 1'b0;
    flag_nxt = flag_nxt & ~flag_clr_wr;
    flag_nxt = flag_nxt | (irq_event & ~LEVEL_MASK);
  end

  // stack pointer next value; interrupt entry counts as a call
  always_comb begin
    sp_nxt = sp_r;
    if (take) sp_nxt = sp_r - 16'h0002;
    else begin
      case (sp_op)
        CSI_SP_PUSH: sp_nxt = sp_r - 16'h0001;
        CSI_SP_POP: sp_nxt = sp_r + 16'h0001;
        CSI_SP_CALL: sp_nxt = sp_r - 16'h0002;
        CSI_SP_RET, CSI_SP_INTERRUPT_RETURN_OP: sp_nxt = sp_r + 16'h0002;
        default: sp_nxt = sp_r;
      endcase
    end
    if (wr_sp_lo) sp_nxt[7:0] = io_wdata;
    if (wr_sp_hi) sp_nxt[15:8] = io_wdata;
  end

  // status register next value; nothing is saved on entry or restored on return
  always_comb begin
    sr_nxt = sr_r;
    if (alu.valid) begin
      sr_nxt[CSI_BIT_N] = alu.result[7];
      sr_nxt[CSI_BIT_Z] = (alu.result == 8'h00);
      sr_nxt[CSI_BIT_C] = alu.carry;
    end
    if (wr_sr) sr_nxt = io_wdata;
    if (global_mask_op) sr_nxt[CSI_BIT_I] = 1'b0;
    if (global_unmask_op || sp_op == CSI_SP_INTERRUPT_RETURN_OP) sr_nxt[CSI_BIT_I] = 1'b1;
    if (take) sr_nxt[CSI_BIT_I] = 1'b0;
  end

  // response sequencer: entry lasts five cycles then presents the vector
  always_comb begin
    case (state_r)
      CSI_RUN: state_nxt = take ? CSI_ENTRY : CSI_RUN;
      // counter runs 1..5 over the entry cycles, so the vector follows the fifth
      CSI_ENTRY: state_nxt = (cnt_r == CSI_IRQ_CYC) ? CSI_VEC : CSI_ENTRY;
      CSI_VEC: state_nxt = CSI_RUN;
      default: state_nxt = CSI_RUN;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state registers; stack pointer resets to the last sram byte
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sp_r <= {SP_HI_RST, SP_LO_RST};
      sr_r <= CSI_SR_RST;
      ccr_r <= 8'h00;
      flag_r <= '0;
      state_r <= CSI_RUN;
    end else begin
      sp_r <= sp_nxt;
      sr_r <= sr_nxt;
      flag_r <= flag_nxt;
      state_r <= state_nxt;
      if (wr_ccr) ccr_r <= io_wdata;
    end
  end

  // counter, grant capture and hold after unmask or return
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      sel_r <= '0;
      hold_r <= 1'b0;
      push_r <= 1'b0;
    end else begin
      cnt_r <= (state_r == CSI_ENTRY) ? cnt_r + 3'h1 : (take ? 3'h1 : 3'h0);
      if (take) sel_r <= grant_idx;
      push_r <= take;
      // one instruction boundary must pass before the next response
      if (global_unmask_op || sp_op == CSI_SP_INTERRUPT_RETURN_OP) hold_r <= 1'b1;
      else if (instr_done) hold_r <= 1'b0;
    end
  end

  // vector output: one word per source above the reset vector
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vec_valid_r <= 1'b0;
      vec_r <= 16'h0000;
    end else begin
      vec_valid_r <= (state_nxt == CSI_VEC);
      if (state_nxt == CSI_VEC)
        vec_r <= vec_base + {{(15 - $clog2(NIRQ)){1'b0}}, sel_r, 1'b0} + 16'h0002;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // io read mux and output wiring
  always_comb begin
    case (io_addr)
      CSI_SP_LO_OFS: io_rdata = io_re ? sp_r[7:0] : 8'h00;
      CSI_SP_HI_OFS: io_rdata = io_re ? sp_r[15:8] : 8'h00;
      CSI_SR_OFS: io_rdata = io_re ? sr_r : 8'h00;
      CSI_CCR_OFS: io_rdata = io_re ? ccr_r : 8'h00;
      default: io_rdata = 8'h00;
    endcase
  end

  assign irq_flags = flag_r;
  assign irq_busy = (state_r != CSI_RUN);
  assign irq_vector_valid = vec_valid_r;
  assign irq_vector = vec_r;
  assign stack_ptr = sp_r;
  assign push_ret = push_r;
  // clock is the undivided core clock; fetch overlaps execute outside
endmodule : csi_core
`default_nettype wire

// file: src/csi_pkg.sv
// package: constants and carrier types for the cpu stack and interrupt control block
package csi_pkg;
  // io-space offsets of the stack pointer bytes, status and control registers, and reset values
  localparam logic [5:0] CSI_SP_LO_OFS = 6'h3d;
  localparam logic [5:0] CSI_SP_HI_OFS = 6'h3e;
  localparam logic [5:0] CSI_SR_OFS = 6'h3f;
  localparam logic [5:0] CSI_CCR_OFS = 6'h35;
  localparam logic [7:0] CSI_SP_LO_RST = 8'hff;
  localparam logic [7:0] CSI_SP_HI_RST = 8'h20;
  localparam logic [7:0] CSI_SR_RST = 8'h00;
  // status flag and control register relocate bit positions
  localparam int CSI_BIT_C = 0;
  localparam int CSI_BIT_Z = 1;
  localparam int CSI_BIT_N = 2;
  localparam int CSI_BIT_I = 7;
  localparam int CSI_BIT_RELOC = 1;
  // file size and pointer pair base
  localparam int CSI_NREG = 32;
  localparam logic [4:0] CSI_PTR_BASE = 5'h1a;
  // interrupt response length in cycles and boot vector table base
  localparam logic [2:0] CSI_IRQ_CYC = 3'h5;
  localparam logic [15:0] CSI_BOOT_BASE = 16'h3800;
  // register file operand scheme
  typedef enum logic [1:0] {
    CSI_W8_1 = 2'h0,
    CSI_W8_2 = 2'h1,
    CSI_W16_2 = 2'h2,
    CSI_W16_1 = 2'h3
  } csi_scheme_e;
  // stack adjustment command
  typedef enum logic [2:0] {
    CSI_SP_NONE = 3'h0,
    CSI_SP_PUSH = 3'h1,
    CSI_SP_POP = 3'h2,
    CSI_SP_CALL = 3'h3,
    CSI_SP_RET = 3'h4,
    CSI_SP_INTERRUPT_RETURN_OP = 3'h5
  } csi_spop_e;
  // alu result to fold into the flags
  typedef struct packed {
    logic valid;
    logic [7:0] result;
    logic carry;
  } csi_alu_s;
  // pointer pair update request
  typedef struct packed {
    logic en;
    logic [1:0] sel;
    logic inc;
    logic dec;
  } csi_ptr_s;
endpackage : csi_pkg

// file: src/csi_regfile.sv
// general purpose register file with 8/16-bit schemes and pointer pairs
`timescale 1ns/100ps
`default_nettype none
module csi_regfile
  import csi_pkg::*;
#(
  parameter int NREG = CSI_NREG
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // operand read
  input wire logic [4:0] rd_a,
  input wire logic [4:0] rd_b,
  output logic [7:0] op_a,
  output logic [7:0] op_b,
  output logic [15:0] op_w,
  // write back
  input wire logic wr_en,
  input wire csi_scheme_e wr_scheme,
  input wire logic [4:0] wr_idx,
  input wire logic [15:0] wr_data,
  // data-space byte access
  input wire logic ds_we,
  input wire logic [4:0] ds_idx,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  // pointer update
  input wire csi_ptr_s ptr,
  output logic [15:0] ptr_val
);
  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] reg_r [NREG];  // register storage
  logic [4:0] ptr_lo;  // low byte index of the selected pair
  logic [4:0] wr_hi;  // upper byte of a word write
  logic wide_wr;  // scheme writes a 16-bit result
  logic [15:0] ptr_nxt;  // pointer after inc/dec
  // combinational reads, both operands in the same cycle
  assign op_a = reg_r[rd_a];
  assign op_b = reg_r[rd_b];
  assign op_w = {reg_r[rd_a | 5'h01], reg_r[rd_a & 5'h1e]};
  assign ds_rdata = reg_r[ds_idx];
  assign ptr_lo = CSI_PTR_BASE + {2'h0, ptr.sel, 1'b0};
  assign ptr_val = {reg_r[ptr_lo | 5'h01], reg_r[ptr_lo]};
  assign ptr_nxt = ptr.inc ? ptr_val + 16'h0001 : ptr_val - 16'h0001;
  assign wide_wr = (wr_scheme == CSI_W16_2) || (wr_scheme == CSI_W16_1);
  assign wr_hi = wr_idx | 5'h01;
  //////////////////////////////////////////////////////////////////////////////
  // single write port per cycle, alu write has priority over data space
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < NREG; i++) reg_r[i] <= 8'h00;
    end else if (wr_en) begin
      if (wide_wr) begin
        reg_r[wr_idx & 5'h1e] <= wr_data[7:0];
        reg_r[wr_hi] <= wr_data[15:8];
      end else begin
        reg_r[wr_idx] <= wr_data[7:0];
      end
    end else if (ds_we) begin
      reg_r[ds_idx] <= ds_wdata;
    end else if (ptr.en && (ptr.inc || ptr.dec)) begin
      reg_r[ptr_lo] <= ptr_nxt[7:0];
      reg_r[ptr_lo | 5'h01] <= ptr_nxt[15:8];
    end
  end
endmodule : csi_regfile
`default_nettype wire

// file: src/csi_irq_arb.sv
// fixed priority interrupt arbiter: lowest index wins
`timescale 1ns/100ps
`default_nettype none
module csi_irq_arb #(
  parameter int N = 8
) (
  // requests
  input wire logic [N-1:0] req,
  // grant
  output logic any,
  output logic [$clog2(N)-1:0] idx,
  output logic [N-1:0] onehot
);
  //////////////////////////////////////////////////////////////////////////////
  // scan from highest index down so the lowest set bit remains
  always_comb begin
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) idx = i[$clog2(N)-1:0];
    end
  end
  assign any = |req;
  assign onehot = any ? (N'(1) << idx) : '0;
endmodule : csi_irq_arb
`default_nettype wire

// file: bench/csi_core_monitor.sv
// port checker for the stack and interrupt control core
`timescale 1ns/100ps
`default_nettype none
module csi_core_monitor
  import csi_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // commands from decode
  input wire logic instr_done,
  input wire csi_spop_e sp_op,
  input wire logic global_mask_op,
  input wire logic global_unmask_op,
  input wire csi_alu_s alu,
  // io access
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_rdata,
  // interrupt response
  input wire logic irq_busy,
  input wire logic irq_vector_valid,
  input wire logic [15:0] stack_ptr,
  input wire logic push_ret
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // step each stack command applies, two's complement
  logic [15:0] step;
  assign step = (sp_op == CSI_SP_PUSH) ? 16'hffff : (sp_op == CSI_SP_POP) ? 16'h0001 :
    (sp_op == CSI_SP_CALL) ? 16'hfffe : 16'h0002;
  // io writes and takes override arithmetic, so leave those cycles out
  property p_sp_step;
    sp_op != CSI_SP_NONE && !instr_done && !io_we |=> stack_ptr == $past(stack_ptr) + $past(step);
  endproperty
  a_sp_step: assert property (p_sp_step) else $error("stack step wrong");
  property p_sp_reset;
    $rose(rst_n) |-> stack_ptr == 16'h20ff;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack reset value wrong");
  property p_entry_push;
    push_ret |-> irq_busy && stack_ptr == $past(stack_ptr) - 16'h0002;
  endproperty
  a_entry_push: assert property (p_entry_push) else $error("entry push wrong");
  property p_vec_time;
    push_ret |-> ##5 irq_vector_valid;
  endproperty
  a_vec_time: assert property (p_vec_time) else $error("vector late or early");
  property p_vec_end;
    irq_vector_valid |=> !irq_vector_valid && !irq_busy;
  endproperty
  a_vec_end: assert property (p_vec_end) else $error("vector pulse too long");
  property p_take_boundary;
    $rose(irq_busy) |-> $past(instr_done);
  endproperty
  a_take_boundary: assert property (p_take_boundary) else $error("take off boundary");
  // a mask in the same cycle as a request must still win
  property p_mask;
    global_mask_op && !io_we |=> !push_ret [*2];
  endproperty
  a_mask: assert property (p_mask) else $error("take after mask");
  property p_unmask;
    global_unmask_op |=> ##1 !push_ret;
  endproperty
  a_unmask: assert property (p_unmask) else $error("take right after unmask");
  property p_nzc;
    $past(alu.valid) && io_re && io_addr == CSI_SR_OFS && !$past(io_we) |->
      io_rdata[2:0] == {$past(alu.result[7]), $past(alu.result) == 8'h00, $past(alu.carry)};
  endproperty
  a_nzc: assert property (p_nzc) else $error("status flags wrong");
  property p_interrupt_return_op;
    sp_op == CSI_SP_INTERRUPT_RETURN_OP && !instr_done && !io_we ##1 io_re && io_addr == CSI_SR_OFS |-> io_rdata[CSI_BIT_I];
  endproperty
  a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("return left enable clear");
endmodule : csi_core_monitor
bind csi_core csi_core_monitor csi_core_monitor_inst (.clock, .rst_n, .instr_done, .sp_op,
  .global_mask_op, .global_unmask_op, .alu, .io_we, .io_re, .io_addr, .io_rdata, .irq_busy,
  .irq_vector_valid, .stack_ptr, .push_ret);
`default_nettype wire

// file: bench/csi_src_model.sv
// peripheral interrupt sources facing the core
`timescale 1ns/100ps
`default_nettype none
module csi_src_model (
  // clock
  input wire logic clock,
  // requests from the bench
  input wire logic [7:0] fire,
  input wire logic [7:0] level,
  // lines into the core
  output logic [7:0] irq_event
);
  // one-cycle event per request; a held request pulses again every other cycle
  logic [7:0] pulse_r;
  always_ff @(posedge clock) begin
    pulse_r <= fire & ~pulse_r;
  end
  // level conditions are live only while they last
  assign irq_event = pulse_r | level;
endmodule : csi_src_model
`default_nettype wire

// file: bench/test_cpu_stack_and_interrupt_control.sv
// self-checking bench for the stack and interrupt control core
`timescale 1ns/100ps
`default_nettype none
module test_cpu_stack_and_interrupt_control;
  import csi_pkg::*;
  logic clock = 1'h0, rst_n = 1'h0, instr_done = 1'h0, global_mask_op = 1'h0, global_unmask_op = 1'h0;
  logic io_we = 1'h0, io_re = 1'h0, wr_en = 1'h0, ds_we = 1'h0, irq_busy, irq_vector_valid, push_ret;
  csi_spop_e sp_op = CSI_SP_NONE;
  csi_alu_s alu = '0;
  csi_scheme_e wr_scheme = CSI_W8_1;
  csi_ptr_s ptr = '0;
  logic [5:0] io_addr = 6'h0;
  logic [4:0] rd_a = 5'h0, rd_b = 5'h0, wr_idx = 5'h0, ds_idx = 5'h0;
  logic [7:0] io_wdata = 8'h0, ds_wdata = 8'h0, io_rdata, op_a, ds_rdata, rv;
  logic [7:0] irq_enable = 8'h0, flag_clr_wr = 8'h0, fire = 8'h0, level = 8'h0, irq_flags, irq_event;
  logic [15:0] wr_data = 16'h0, op_w, ptr_val, irq_vector, stack_ptr;
  int num_errors = 0, checked = 0;
  // source 7 is the level-type source
  csi_core #(.LEVEL_MASK(8'h80)) csi_core_inst (.clock, .rst_n, .instr_done, .sp_op, .global_mask_op,
    .global_unmask_op, .alu, .io_we, .io_re, .io_addr, .io_wdata, .io_rdata, .rd_a, .rd_b, .op_a,
    .op_b(), .op_w, .wr_en, .wr_scheme, .wr_idx, .wr_data, .ds_we, .ds_idx, .ds_wdata, .ds_rdata,
    .ptr, .ptr_val, .irq_event, .irq_enable, .flag_clr_wr, .irq_flags, .irq_busy, .irq_vector_valid,
    .irq_vector, .stack_ptr, .push_ret);
  csi_src_model csi_src_model_inst (.clock, .fire, .level, .irq_event);
  always #10 clock = ~clock;
  ////////////////////////////////////////////////////////////
  // every drive lands 1 ns after a rising edge
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // a spare cycle after the write keeps the strobe edges apart
  task automatic io_wr(logic [5:0] a, logic [7:0] d);
    io_we = 1'h1;
    io_addr = a;
    io_wdata = d;
    cyc();
    io_we = 1'h0;
    cyc();
  endtask : io_wr
  task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
    io_re = 1'h1;
    io_addr = a;
    #2;
    d = io_rdata;
    cyc();
  endtask : io_rd
  // hold the boundary until the core takes, then wait for the vector
  task automatic take(logic [15:0] e);
    int n = 0;
    instr_done = 1'h1;
    while (irq_busy !== 1'h1 && n < 4) begin
      cyc();
      n++;
    end
    instr_done = 1'h0;
    while (irq_vector_valid !== 1'h1 && n < 16) begin
      cyc();
      n++;
    end
    cmp("vector", e, irq_vector);
  endtask : take
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    io_rd(CSI_SP_LO_OFS, rv);
    cmp("sp low", 16'h00ff, {8'h0, rv});
    io_rd(CSI_SP_HI_OFS, rv);
    cmp("sp high", 16'h0020, {8'h0, rv});
    io_rd(6'h10, rv);
    cmp("unmapped", 16'h0, {8'h0, rv});
    $display("reset test done");
  endtask : t_reset
  task automatic t_stack();
    csi_spop_e ops[5] = '{CSI_SP_PUSH, CSI_SP_POP, CSI_SP_CALL, CSI_SP_RET, CSI_SP_INTERRUPT_RETURN_OP};
    logic [15:0] dl[5] = '{16'hffff, 16'h1, 16'hfffe, 16'h2, 16'h2};
    logic [15:0] e = 16'h0400;
    io_wr(CSI_SP_HI_OFS, 8'h04);
    io_wr(CSI_SP_LO_OFS, 8'h00);
    io_rd(CSI_SP_HI_OFS, rv);
    cmp("sp high rw", 16'h0004, {8'h0, rv});
    // back to back commands, one per cycle
    for (int i = 0; i < 5; i++) begin
      sp_op = ops[i];
      cyc();
      e = e + dl[i];
      cmp("sp", e, stack_ptr);
    end
    sp_op = CSI_SP_NONE;
    io_rd(CSI_SR_OFS, rv);
    cmp("enable after return", 16'h1, {15'h0, rv[7]});
    $display("stack test done");
  endtask : t_stack
  task automatic t_flags();
    logic [7:0] res[2] = '{8'h80, 8'h00};
    logic [2:0] ex[2] = '{3'h4, 3'h3};
    for (int i = 0; i < 2; i++) begin
      alu = '{1'h1, res[i], i[0]};
      cyc();
      alu = '0;
      io_rd(CSI_SR_OFS, rv);
      cmp("nzc", {13'h0, ex[i]}, {13'h0, rv[2:0]});
    end
    $display("flag test done");
  endtask : t_flags
  task automatic t_regs();
    csi_scheme_e sc[4] = '{CSI_W8_1, CSI_W8_2, CSI_W16_2, CSI_W16_1};
    logic [4:0] ix[4] = '{5'h05, 5'h06, 5'h1a, 5'h1c};
    logic [15:0] wd[4] = '{16'h00a5, 16'h005a, 16'h1234, 16'hbeef};
    for (int i = 0; i < 4; i++) begin
      wr_en = 1'h1;
      wr_scheme = sc[i];
      wr_idx = ix[i];
      wr_data = wd[i];
      cyc();
      wr_en = 1'h0;
      rd_a = ix[i];
      #1;
      cmp("reg", wd[i], sc[i][1] ? op_w : {8'h0, op_a});
      cyc();
    end
    ds_idx = 5'h1b;
    ptr = '{1'h1, 2'h0, 1'h1, 1'h0};
    #1;
    cmp("ds", 16'h0012, {8'h0, ds_rdata});
    cmp("ptr", 16'h1234, ptr_val);
    cyc();
    cmp("ptr inc", 16'h1235, ptr_val);
    ptr = '{1'h1, 2'h1, 1'h0, 1'h1};
    #1;
    cmp("ptr y", 16'hbeef, ptr_val);
    cyc();
    ptr = '{1'h0, 2'h1, 1'h0, 1'h0};
    #1;
    cmp("ptr dec", 16'hbeee, ptr_val);
    $display("register test done");
  endtask : t_regs
  task automatic t_irq();
    io_wr(CSI_SR_OFS, 8'h00);
    fire = 8'h0a;
    cyc();
    fire = 8'h00;
    instr_done = 1'h1;
    cyc(3);
    instr_done = 1'h0;
    cmp("pending", 16'h000a, {8'h0, irq_flags});
    cmp("masked busy", 16'h0, {15'h0, irq_busy});
    irq_enable = 8'h0e;
    io_wr(CSI_SR_OFS, 8'h80);
    take(16'h0004);
    cmp("flags after take", 16'h0008, {8'h0, irq_flags});
    io_rd(CSI_SR_OFS, rv);
    cmp("enable after entry", 16'h0, {15'h0, rv[7]});
    flag_clr_wr = 8'h08;
    cyc();
    flag_clr_wr = 8'h00;
    cmp("write one clear", 16'h0, {8'h0, irq_flags});
    io_wr(CSI_CCR_OFS, 8'h02);
    fire = 8'h04;
    cyc();
    fire = 8'h00;
    io_wr(CSI_SR_OFS, 8'h80);
    take(CSI_BOOT_BASE + 16'h6);
    io_wr(CSI_CCR_OFS, 8'h00);
    // a level that goes away before enabling is never served
    level = 8'h80;
    cyc(2);
    level = 8'h00;
    irq_enable = 8'h80;
    io_wr(CSI_SR_OFS, 8'h80);
    instr_done = 1'h1;
    cyc(3);
    instr_done = 1'h0;
    cmp("vanished level", 16'h0, {15'h0, irq_busy});
    level = 8'h80;
    take(16'h0010);
    level = 8'h00;
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_mask();
    irq_enable = 8'h02;
    fire = 8'h02;
    cyc();
    fire = 8'h00;
    global_unmask_op = 1'h1;
    cyc();
    global_unmask_op = 1'h0;
    // first boundary after unmask is not taken, the hold lets it run
    instr_done = 1'h1;
    cyc();
    cmp("take after unmask", 16'h0, {15'h0, irq_busy});
    // now enabled and unheld: only the mask in the same cycle blocks it
    global_mask_op = 1'h1;
    cyc();
    global_mask_op = 1'h0;
    cyc(3);
    instr_done = 1'h0;
    cmp("masked take", 16'h0, {15'h0, irq_busy});
    cmp("still pending", 16'h0002, {8'h0, irq_flags});
    $display("mask test done");
  endtask : t_mask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(10);
    rst_n = 1'h1;
    cyc();
    t_reset();
    t_stack();
    t_flags();
    t_regs();
    t_irq();
    t_mask();
    conclude();
  end
  // the run needs under a hundred cycles; a thousand means a hang
  initial begin
    #20000;
    num_errors++;
    conclude();
  end
endmodule : test_cpu_stack_and_interrupt_control
`default_nettype wire
